// ===== core/pdl_latch.sv
// Digital front end of a 10-bit current-steering DAC
// How it works
// - Sample word is 10-bit unsigned binary, top line is the MSB.
// - All-ones latched code steers full-scale current to the primary output.
// - Complement output carries the inverse code, the share primary does not.
// - Data captured on rising clock edge; output updates only on that edge.
// - Latch path runs at up to 210 MSPS; here one sample per clock.
// - Power-down input high turns both output currents off.
// - Power-down pin pulled low internally; open pin keeps device converting.
// - Power-down completes within 50 ns; wake takes about 5 us. Here entry takes up to five 100 ns cycles.
`timescale 1ns/1ps
module pdl_latch (
   // Clock and reset
   input  wire logic                       ref_clk_i,
   input  wire logic                       rst_n_i,
   // Sample word from the data source
   input  wire logic [pdl_pkg::DATA_W-1:0] data_word_i,
   // Power-down pin level and whether the pad is driven (low means the pad is open)
   input  wire logic                       power_down_i,
   input  wire logic                       power_down_oe_i,
   // Output current codes
   output logic [pdl_pkg::DATA_W-1:0]      current_out_primary_o,
   output logic [pdl_pkg::DATA_W-1:0]      current_out_complement_o,
   output logic                            current_on_o,
   output logic                            output_valid_o
);
   logic [pdl_pkg::DATA_W-1:0] word_q;
   logic                       pd_pin;
   logic                       pd_level;
   logic [pdl_pkg::WAKE_W-1:0] wake_cnt_q;
   pdl_pkg::pdl_state_e        state_q;

   // An undriven pad reads as low, keeping the device enabled
   assign pd_pin = power_down_oe_i & power_down_i;

   // Data lines come from logic on this clock, so no synchroniser
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         word_q <= pdl_pkg::CODE_RESET;
      end else begin
         word_q <= data_word_i;
      end
   end

   pdl_sync u_pd_sync (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .async_i   (pd_pin),
      .level_o   (pd_level)
   );

   // The sync delay costs four cycles, inside the 50 ns only at faster clocks;
   // at 10 MHz one cycle already exceeds it, so entry is as fast as we can
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_q    <= pdl_pkg::PDL_ST_RUN;
         wake_cnt_q <= pdl_pkg::WAKE_ZERO;
      end else begin
         case (state_q)
            pdl_pkg::PDL_ST_RUN: begin
               if (pd_level) begin
                  state_q <= pdl_pkg::PDL_ST_SLEEP;
               end
            end
            pdl_pkg::PDL_ST_SLEEP: begin
               if (!pd_level) begin
                  state_q    <= pdl_pkg::PDL_ST_WAKE;
                  wake_cnt_q <= pdl_pkg::WAKE_LOAD;
               end
            end
            pdl_pkg::PDL_ST_WAKE: begin
               if (pd_level) begin
                  state_q <= pdl_pkg::PDL_ST_SLEEP;
               end else if (wake_cnt_q == pdl_pkg::WAKE_ZERO) begin
                  state_q <= pdl_pkg::PDL_ST_RUN;
               end else begin
                  wake_cnt_q <= wake_cnt_q - 7'h01;
               end
            end
            default: begin
               state_q <= pdl_pkg::PDL_ST_RUN;
            end
         endcase
      end
   end

   // Output codes follow the latched word one edge later, gated by power state
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         current_out_primary_o    <= pdl_pkg::CODE_RESET;
         current_out_complement_o <= pdl_pkg::CODE_RESET;
         current_on_o             <= 1'b0;
         output_valid_o           <= 1'b0;
      end else if (state_q == pdl_pkg::PDL_ST_RUN && !pd_level) begin
         current_out_primary_o    <= word_q;
         current_out_complement_o <= pdl_pkg::CODE_FULL - word_q;
         current_on_o             <= 1'b1;
         output_valid_o           <= 1'b1;
      end else begin
         current_out_primary_o    <= pdl_pkg::CODE_RESET;
         current_out_complement_o <= pdl_pkg::CODE_RESET;
         current_on_o             <= 1'b0;
         output_valid_o           <= 1'b0;
      end
   end

   // Assertions
   sequence s_sleep_seen;
      pd_level;
   endsequence

   sequence s_wake_done;
      (!pd_level && state_q == pdl_pkg::PDL_ST_WAKE && wake_cnt_q == pdl_pkg::WAKE_ZERO);
   endsequence

   chk_primary_follows: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state_q == pdl_pkg::PDL_ST_RUN && !pd_level) |=>
         current_out_primary_o == $past(word_q))
      else $error("primary output does not follow latched word");

   chk_full_scale: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state_q == pdl_pkg::PDL_ST_RUN && !pd_level && word_q == pdl_pkg::CODE_FULL) |=>
         (current_out_primary_o == pdl_pkg::CODE_FULL && current_out_complement_o == 10'h000))
      else $error("all-ones code not at full scale");

   chk_complement_sum: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      current_on_o |-> (current_out_primary_o + current_out_complement_o) == pdl_pkg::CODE_FULL)
      else $error("outputs do not share full scale");

   chk_sleep_off: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_sleep_seen |=> (!current_on_o && current_out_primary_o == 10'h000))
      else $error("current not off in power-down");

   chk_pin_open: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (!power_down_oe_i)[*5] |=> !pd_level)
      else $error("undriven power-down pin acts as high");

   chk_enter_bound: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(pd_pin) |-> ##[1:5] !current_on_o)
      else $error("power-down entry too slow");

   chk_wake_hold: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      $fell(pd_level) |-> (!current_on_o)[*8])
      else $error("output valid too early after wake");

   chk_wake_resume: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_wake_done |=> ##1 (current_on_o && current_out_primary_o == $past(word_q)))
      else $error("updates did not resume after wake");

   // Cycles since the filtered power-down level was last high, saturating.
   // Lets the wake check span the whole wait, which a repetition cannot reach.
   logic [pdl_pkg::WAKE_W-1:0] since_fall_q;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         since_fall_q <= 7'h7F;
      end else if (pd_level) begin
         since_fall_q <= 7'h00;
      end else if (since_fall_q != 7'h7F) begin
         since_fall_q <= since_fall_q + 7'h01;
      end
   end

   sequence s_running;
      (state_q == pdl_pkg::PDL_ST_RUN && !pd_level);
   endsequence

   sequence s_wake_counting;
      (state_q == pdl_pkg::PDL_ST_WAKE && !pd_level && wake_cnt_q != pdl_pkg::WAKE_ZERO);
   endsequence

   chk_wake_wait: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(current_on_o) |-> since_fall_q > pdl_pkg::WAKE_LOAD)
      else $error("output came back before the wake time");

   chk_wake_count: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_wake_counting |=> (wake_cnt_q == $past(wake_cnt_q) - 7'h01))
      else $error("wake counter did not step down");

   chk_wake_exit: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_wake_done |=> state_q == pdl_pkg::PDL_ST_RUN)
      else $error("wake did not return to running");

   chk_run_outputs: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_running |=> current_on_o)
      else $error("running state left the current off");

   chk_valid_tracks: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      output_valid_o == current_on_o)
      else $error("valid flag differs from current on");

   chk_off_zero: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !current_on_o |-> (current_out_primary_o == 10'h000 && current_out_complement_o == 10'h000))
      else $error("current codes not zero while off");

   chk_sleep_state: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_sleep_seen |=> state_q != pdl_pkg::PDL_ST_RUN)
      else $error("power-down level did not leave running");

   chk_open_idle: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !power_down_oe_i |-> !pd_pin)
      else $error("open power-down pad does not read low");

   chk_word_capture: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      1'b1 |=> word_q == $past(data_word_i))
      else $error("sample word not captured on the rising edge");
endmodule : pdl_latch

// ===== core/pdl_pkg.sv
// Constants shared by the parallel DAC input latch
package pdl_pkg;
   localparam int unsigned          DATA_W          = 10;
   localparam logic [9:0]           CODE_FULL       = 10'h3FF;
   localparam logic [9:0]           CODE_RESET      = 10'h000;
   // Clock rate and timing figures
   localparam int unsigned          CLK_PERIOD_NS   = 100;
   localparam int unsigned          MAX_RATE_MSPS   = 210;
   localparam int unsigned          PD_ENTER_NS     = 50;
   localparam int unsigned          PD_EXIT_NS      = 5000;
   // Longest time rounds down, never below one cycle
   localparam int unsigned          PD_ENTER_CYC    = (PD_ENTER_NS / CLK_PERIOD_NS) < 1 ?
                                                      1 : (PD_ENTER_NS / CLK_PERIOD_NS);
   // Least time rounds up
   localparam int unsigned          PD_EXIT_CYC     = (PD_EXIT_NS + CLK_PERIOD_NS - 1)
                                                      / CLK_PERIOD_NS;
   localparam int unsigned          WAKE_W          = 7;
   localparam logic [WAKE_W-1:0]    WAKE_LOAD       = WAKE_W'(PD_EXIT_CYC - 1);
   localparam logic [WAKE_W-1:0]    WAKE_ZERO       = 7'h00;
   typedef enum logic [1:0] {
      PDL_ST_RUN   = 2'b00,
      PDL_ST_SLEEP = 2'b01,
      PDL_ST_WAKE  = 2'b10
   } pdl_state_e;
endpackage : pdl_pkg

// ===== core/pdl_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pdl_sync (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   // Asynchronous level in, filtered level out
   input  wire logic async_i,
   output logic      level_o
);
   logic [2:0] stage_q;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         stage_q <= 3'h0;
      end else begin
         stage_q <= {stage_q[1:0], async_i};
      end
   end

   // Only stages two and three are compared; stage one stays private
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         level_o <= 1'b0;
      end else if (stage_q[1] == stage_q[2]) begin
         level_o <= stage_q[2];
      end
   end
endmodule : pdl_sync

// ===== tb/parallel_dac_input_latch_test.sv
// Self-checking bench for the parallel DAC input latch
`timescale 1ns/1ps
module parallel_dac_input_latch_test;
   logic       ref_clk_i, rst_n_i, power_down_i, power_down_oe_i, run, on_o, valid_o;
   logic [9:0] start, data_word, prim_o, comp_o, w1, w2;
   int         mismatches, tests_run, n;
   pdl_latch dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .data_word_i(data_word),
      .power_down_i(power_down_i), .power_down_oe_i(power_down_oe_i),
      .current_out_primary_o(prim_o), .current_out_complement_o(comp_o),
      .current_on_o(on_o), .output_valid_o(valid_o));
   pdl_source src (.ref_clk_i(ref_clk_i), .run_i(run), .start_i(start), .word_o(data_word));
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   // Word history: w2 is the word the output should show after each edge
   always @(posedge ref_clk_i) begin
      w1 <= data_word;
      w2 <= w1;
   end
   task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   task automatic test_stream();
      @(posedge ref_clk_i) run <= 1'b1;
      repeat (3) @(negedge ref_clk_i);
      repeat (10) begin
         @(negedge ref_clk_i);
         check("primary code", prim_o, w2);
         check("complement code", comp_o, 10'h3FF - w2);
         check("current on", {9'h000, on_o}, 10'h001);
         check("output valid", {9'h000, valid_o}, 10'h001);
      end
      $display("test_stream done");
   endtask : test_stream
   task automatic test_sleep();
      @(posedge ref_clk_i) power_down_i <= 1'b1;
      n = 0;
      while (on_o === 1'b1 && n < 8) begin
         @(negedge ref_clk_i);
         n++;
      end
      // Synchroniser delay means entry takes a few cycles, not 50 ns
      check("enter in time", {9'h000, n <= 6}, 10'h001);
      check("current off", {9'h000, on_o}, 10'h000);
      check("valid off", {9'h000, valid_o}, 10'h000);
      check("primary asleep", prim_o, 10'h000);
      check("complement asleep", comp_o, 10'h000);
      @(posedge ref_clk_i) power_down_i <= 1'b0;
      n = 0;
      while (valid_o !== 1'b1 && n < 80) begin
         @(negedge ref_clk_i);
         n++;
      end
      check("wake wait", {9'h000, n >= 50 && n <= 62}, 10'h001);
      check("primary after wake", prim_o, w2);
      @(negedge ref_clk_i);
      check("update resumes", prim_o, w2);
      $display("test_sleep done");
   endtask : test_sleep
   task automatic test_open_pin();
      @(posedge ref_clk_i) begin
         power_down_oe_i <= 1'b0;
         power_down_i    <= 1'b1;
      end
      repeat (10) begin
         @(negedge ref_clk_i);
         check("open pin stays on", {9'h000, on_o}, 10'h001);
      end
      @(posedge ref_clk_i) begin
         power_down_oe_i <= 1'b1;
         power_down_i    <= 1'b0;
      end
      $display("test_open_pin done");
   endtask : test_open_pin
   initial begin
      rst_n_i = 1'b0;
      power_down_i = 1'b0;
      power_down_oe_i = 1'b1;
      run = 1'b0;
      start = 10'h3FC;
      mismatches = 0;
      tests_run = 0;
      repeat (20) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      test_stream();
      test_sleep();
      test_open_pin();
      print_verdict();
   end
   initial begin
      #(2000 * 100);
      mismatches++;
      print_verdict();
   end
endmodule : parallel_dac_input_latch_test

// ===== tb/pdl_source.sv
// Sample source model driving a wrapping ramp of words
`timescale 1ns/1ps
module pdl_source (
   // Clock and control
   input  wire logic       ref_clk_i,
   input  wire logic       run_i,
   input  wire logic [9:0] start_i,
   // Sample word to the latch
   output logic [9:0]      word_o
);
   // Ramp wraps past full scale so both end codes are sent back to back
   always_ff @(posedge ref_clk_i) begin
      // Changes just after the edge, so the word holds steady up to the next capture
      word_o <= run_i ? word_o + 10'h001 : start_i;
   end
endmodule : pdl_source
